//--- hdl/mipd_pkg.sv
// ==========================================================================
// Shared constants, carriers and helpers of the interrupt dispatcher
package mipd_pkg;

  // ========================================================================
  // Special function register addresses
  localparam logic [7:0] MIPD_ADDR_TIMER_CONTROL_BITS = 8'h88;
  localparam logic [7:0] MIPD_ADDR_SCON = 8'h98;
  localparam logic [7:0] MIPD_ADDR_IE   = 8'ha8;
  localparam logic [7:0] MIPD_ADDR_IPH  = 8'hb7;
  localparam logic [7:0] MIPD_ADDR_IP   = 8'hb8;

  // ========================================================================
  // Field positions and implemented-bit masks
  localparam int         MIPD_TC_IT0    = 0;
  localparam int         MIPD_TC_IE0    = 1;
  localparam int         MIPD_TC_IT1    = 2;
  localparam int         MIPD_TC_IE1    = 3;
  localparam int         MIPD_TC_TF0    = 5;
  localparam int         MIPD_TC_TF1    = 7;
  localparam int         MIPD_SC_RI     = 0;
  localparam int         MIPD_SC_TI     = 1;
  localparam int         MIPD_EN_GLOBAL = 7;
  localparam logic [7:0] MIPD_EN_MASK   = 8'h9f;
  localparam logic [7:0] MIPD_PRIO_MASK = 8'h1f;

  // Source positions, also the polling order
  localparam logic [2:0] MIPD_SRC_EXT0  = 3'h0;
  localparam logic [2:0] MIPD_SRC_TMR0  = 3'h1;
  localparam logic [2:0] MIPD_SRC_EXT1  = 3'h2;
  localparam logic [2:0] MIPD_SRC_TMR1  = 3'h3;

  // Reset values and vector layout
  localparam logic [7:0]  MIPD_REG_RST  = 8'h00;
  localparam logic [15:0] MIPD_VEC_BASE = 16'h0003;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mipd_sfr_req_t;

  typedef struct packed {
    logic tick;
    logic last_cycle;
    logic return_from_interrupt;
  } mipd_core_t;

  typedef struct packed {
    logic t0_roll;
    logic t1_roll;
    logic rx_done;
    logic tx_done;
  } mipd_evt_t;

  typedef struct packed {
    logic        long_subroutine_call;
    logic [15:0] vector;
  } mipd_call_t;

  typedef struct packed {
    logic seen_high;
  } mipd_smp_t;

  typedef struct packed {
    logic [7:0] ie;
    logic [7:0] ip;
    logic [7:0] irq_priority_high_bits;
    logic       it0;
    logic       it1;
    logic       ie0;
    logic       ie1;
    logic       tf0;
    logic       tf1;
    logic       ri;
    logic       ti;
    logic [4:0] smp;
    logic [3:0] act;
    logic       blk;
    mipd_call_t call;
    logic [7:0] rdata;
  } mipd_state_t;

  // ========================================================================
  // Helpers
  function automatic logic [1:0] mipd_level(input logic hi, input logic lo);
    return {hi, lo};
  endfunction

  function automatic logic [15:0] mipd_vector(input logic [2:0] idx);
    return MIPD_VEC_BASE + {10'h000, idx, 3'h0};
  endfunction

endpackage

//--- hdl/mipd_pin_sampler.sv
`timescale 1ns/1ns
// ==========================================================================
// Machine-cycle sampler for one external request pin
module mipd_pin_sampler
  import mipd_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic tick_in,
  input  wire logic pin_in,
  output logic      fall_out,
  output logic      low_out
);

  mipd_smp_t s_q;
  mipd_smp_t s_d;

  // Keep the previous machine-cycle sample only
  always_comb begin
    s_d = s_q;
    if (tick_in) begin
      s_d.seen_high = pin_in;
    end
  end

  // Reset to low so a pin already low gives no false edge
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // High in one sample and low in the next
  assign fall_out = tick_in & s_q.seen_high & ~pin_in;
  assign low_out  = tick_in & ~pin_in;

endmodule

//--- hdl/mipd_arbiter.sv
`timescale 1ns/1ns
// ==========================================================================
// Picks the highest level, then the earliest source in polling order
module mipd_arbiter
  import mipd_pkg::*;
(
  input  wire logic [4:0] req_in,
  input  wire logic [4:0] prio_hi_in,
  input  wire logic [4:0] prio_lo_in,
  output logic            valid_out,
  output logic [2:0]      idx_out,
  output logic [1:0]      level_out
);

  // Walk from the last source back; ties go to the earlier source
  always_comb begin
    logic [1:0] lvl;
    lvl       = 2'h0;
    valid_out = 1'b0;
    idx_out   = 3'h0;
    level_out = 2'h0;
    for (int i = 4; i >= 0; i--) begin
      lvl = mipd_level(prio_hi_in[i], prio_lo_in[i]);
      if (req_in[i] && (!valid_out || lvl >= level_out)) begin
        valid_out = 1'b1;
        idx_out   = 3'(i);
        level_out = lvl;
      end
    end
  end

endmodule

//--- hdl/mipd_dispatch.sv
`timescale 1ns/1ns
// ==========================================================================
module mipd_dispatch
  import mipd_pkg::*;
(
  input  wire logic    clk_in,
  input  wire logic    sys_rst_in,
  input  mipd_core_t   core_in,
  input  mipd_sfr_req_t sfr_in,
  input  mipd_evt_t    periph_in,
  input  wire logic    ext_irq_pin_0_in,
  input  wire logic    ext_irq_pin_1_in,
  output logic [7:0]   sfr_rdata_out,
  output mipd_call_t   call_out,
  output logic [3:0]   in_service_out
);

  // ========================================================================
  // Declarations
  mipd_state_t s_q;
  mipd_state_t s_d;
  logic        fall0;
  logic        fall1;
  logic        low0;
  logic        low1;
  logic [4:0]  req;
  logic        win_valid;
  logic [2:0]  win_idx;
  logic [1:0]  win_lvl;
  logic        ctrl_wr;
  logic        blk_now;
  logic        lvl_block;
  logic        take;

  // Mask of levels at or above a given level
  function automatic logic [3:0] at_or_above(input logic [1:0] lvl);
    return 4'hf << lvl;
  endfunction

  // Index of the highest level in service
  function automatic logic [1:0] top_level(input logic [3:0] act);
    logic [1:0] top;
    top = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (act[l]) begin
        top = 2'(l);
      end
    end
    return top;
  endfunction

  // ========================================================================
  // External pin samplers
  mipd_pin_sampler u_pin0 (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (core_in.tick),
    .pin_in     (ext_irq_pin_0_in),
    .fall_out   (fall0),
    .low_out    (low0)
  );

  mipd_pin_sampler u_pin1 (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (core_in.tick),
    .pin_in     (ext_irq_pin_1_in),
    .fall_out   (fall1),
    .low_out    (low1)
  );

  // ========================================================================
  // Request selection
  // Only samples taken at the previous tick are polled
  assign req = s_q.smp & s_q.ie[4:0] & {5{s_q.ie[MIPD_EN_GLOBAL]}};

  mipd_arbiter u_arb (
    .req_in     (req),
    .prio_hi_in (s_q.irq_priority_high_bits[4:0]),
    .prio_lo_in (s_q.ip[4:0]),
    .valid_out  (win_valid),
    .idx_out    (win_idx),
    .level_out  (win_lvl)
  );

  // Writes to enable or priority registers hold off vectoring
  assign ctrl_wr = sfr_in.wr & (sfr_in.addr == MIPD_ADDR_IE ||
                                sfr_in.addr == MIPD_ADDR_IP ||
                                sfr_in.addr == MIPD_ADDR_IPH);
  assign blk_now = s_q.blk | core_in.return_from_interrupt | ctrl_wr;

  // A level already in service at or above the winner blocks it
  assign lvl_block = |(s_q.act & at_or_above(win_lvl));

  // Vector only at the poll of an instruction's final cycle
  assign take = core_in.tick & core_in.last_cycle & win_valid &
                ~blk_now & ~lvl_block;

  // ========================================================================
  // Next state
  always_comb begin
    s_d            = s_q;
    s_d.call.long_subroutine_call = 1'b0;

    // Software writes; every request flag is writable
    if (sfr_in.wr) begin
      case (sfr_in.addr)
        MIPD_ADDR_IE: begin
          s_d.ie = sfr_in.wdata & MIPD_EN_MASK;
        end
        MIPD_ADDR_IP: begin
          s_d.ip = sfr_in.wdata & MIPD_PRIO_MASK;
        end
        MIPD_ADDR_IPH: begin
          s_d.irq_priority_high_bits = sfr_in.wdata & MIPD_PRIO_MASK;
        end
        MIPD_ADDR_TIMER_CONTROL_BITS: begin
          s_d.it0 = sfr_in.wdata[MIPD_TC_IT0];
          s_d.it1 = sfr_in.wdata[MIPD_TC_IT1];
          s_d.ie0 = sfr_in.wdata[MIPD_TC_IE0];
          s_d.ie1 = sfr_in.wdata[MIPD_TC_IE1];
          s_d.tf0 = sfr_in.wdata[MIPD_TC_TF0];
          s_d.tf1 = sfr_in.wdata[MIPD_TC_TF1];
        end
        MIPD_ADDR_SCON: begin
          s_d.ri = sfr_in.wdata[MIPD_SC_RI];
          s_d.ti = sfr_in.wdata[MIPD_SC_TI];
        end
        default: begin
          s_d.rdata = s_d.rdata;
        end
      endcase
    end

    // Return from a routine releases its level; execution then resumes
    if (core_in.return_from_interrupt && (s_q.act != 4'h0)) begin
      s_d.act[top_level(s_q.act)] = 1'b0;
    end

    // Issue the call; the core pushes only the program counter
    if (take) begin
      s_d.call.long_subroutine_call        = 1'b1;
      s_d.call.vector       = mipd_vector(win_idx);
      s_d.act[win_lvl]      = 1'b1;
      if (win_idx == MIPD_SRC_EXT0 && s_q.it0) begin
        s_d.ie0 = 1'b0;
      end
      if (win_idx == MIPD_SRC_EXT1 && s_q.it1) begin
        s_d.ie1 = 1'b0;
      end
      if (win_idx == MIPD_SRC_TMR0) begin
        s_d.tf0 = 1'b0;
      end
      if (win_idx == MIPD_SRC_TMR1) begin
        s_d.tf1 = 1'b0;
      end
    end

    // Hardware sets come last so a set beats any clear
    if (core_in.tick && !s_q.it0) begin
      s_d.ie0 = low0;
    end else if (fall0) begin
      s_d.ie0 = 1'b1;
    end
    if (core_in.tick && !s_q.it1) begin
      s_d.ie1 = low1;
    end else if (fall1) begin
      s_d.ie1 = 1'b1;
    end
    if (periph_in.t0_roll) begin
      s_d.tf0 = 1'b1;
    end
    if (periph_in.t1_roll) begin
      s_d.tf1 = 1'b1;
    end
    if (periph_in.rx_done) begin
      s_d.ri = 1'b1;
    end
    if (periph_in.tx_done) begin
      s_d.ti = 1'b1;
    end

    // Latch flags once per machine cycle for the next poll
    if (core_in.tick) begin
      s_d.smp = {s_q.ri | s_q.ti, s_q.tf1, s_q.ie1, s_q.tf0, s_q.ie0};
    end

    // Hold-off lasts until the blocked instruction has finished
    s_d.blk = blk_now & ~(core_in.tick & core_in.last_cycle);

    // Read data follows the address one cycle later
    case (sfr_in.addr)
      MIPD_ADDR_IE:   s_d.rdata = s_q.ie;
      MIPD_ADDR_IP:   s_d.rdata = s_q.ip;
      MIPD_ADDR_IPH:  s_d.rdata = s_q.irq_priority_high_bits;
      MIPD_ADDR_TIMER_CONTROL_BITS: s_d.rdata = {s_q.tf1, 1'b0, s_q.tf0, 1'b0,
                                   s_q.ie1, s_q.it1, s_q.ie0, s_q.it0};
      MIPD_ADDR_SCON: s_d.rdata = {6'h00, s_q.ti, s_q.ri};
      default:        s_d.rdata = MIPD_REG_RST;
    endcase
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // Outputs
  assign sfr_rdata_out  = s_q.rdata;
  assign call_out       = s_q.call;
  assign in_service_out = s_q.act;

  // ========================================================================
  // Checks
  a_call_final_cycle: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    s_q.call.long_subroutine_call |-> $past(core_in.tick) && $past(core_in.last_cycle))
    else $error("Call issued outside a final instruction cycle");

  a_call_enabled: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    s_q.call.long_subroutine_call |-> $past(s_q.ie[MIPD_EN_GLOBAL]))
    else $error("Call issued with global enable clear");

  a_vector_fixed: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    s_q.call.long_subroutine_call |-> (s_q.call.vector[2:0] == 3'h3) && (s_q.call.vector <= 16'h0023))
    else $error("Vector outside the fixed table");

  a_return_from_interrupt_holdoff: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (core_in.return_from_interrupt || ctrl_wr) |=> !s_q.call.long_subroutine_call)
    else $error("Call issued during return or control write");

  a_edge_clear: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (s_q.call.long_subroutine_call && s_q.call.vector == 16'h0003 && $past(s_q.it0) &&
     !$past(fall0) && !$past(sfr_in.wr)) |-> !s_q.ie0)
    else $error("Edge flag kept after vectoring");

  a_timer_clear: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (s_q.call.long_subroutine_call && s_q.call.vector == 16'h000b && !$past(periph_in.t0_roll) &&
     !$past(sfr_in.wr)) |-> !s_q.tf0)
    else $error("Timer flag kept after vectoring");

  a_serial_kept: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (s_q.ri && !sfr_in.wr) |=> s_q.ri)
    else $error("Receive flag cleared without software");

  a_nest_rises: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    s_q.call.long_subroutine_call |-> (s_q.act > $past(s_q.act)) && !$past(core_in.return_from_interrupt))
    else $error("Call did not raise the in-service level");

  a_level_follows: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (core_in.tick && !s_q.it0) |=> (s_q.ie0 == $past(low0)))
    else $error("Level flag does not follow the pin");

  a_edge_sets: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (fall1 && s_q.it1) |=> s_q.ie1)
    else $error("Falling edge did not set the flag");

  a_timer_sets: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    periph_in.t0_roll |=> s_q.tf0)
    else $error("Rollover did not set the timer flag");

  a_poll_held: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !core_in.tick |=> $stable(s_q.smp))
    else $error("Samples changed between machine cycles");

  a_serial_sampled: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (s_q.call.long_subroutine_call && s_q.call.vector == 16'h0023) |-> $past(s_q.smp[4]))
    else $error("Serial call without a sampled serial flag");

  a_source_enabled: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (s_q.call.long_subroutine_call && s_q.call.vector == 16'h000b) |-> $past(s_q.ie[1]))
    else $error("Timer call with its enable clear");

  a_release_top: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (core_in.return_from_interrupt && s_q.act != 4'h0) |=> (s_q.act < $past(s_q.act)))
    else $error("Return did not release a level");

  a_call_single: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    s_q.call.long_subroutine_call |=> !s_q.call.long_subroutine_call)
    else $error("Call lasted more than one cycle");

  a_prio_unused: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (s_q.ip[7:5] == 3'h0) && (s_q.irq_priority_high_bits[7:5] == 3'h0))
    else $error("Reserved priority bits were stored");

endmodule

//--- tb/mipd_core_model.sv
`timescale 1ns/1ns
// ==========================================================================
// Instruction sequencer stand-in: machine-cycle ticks, instruction ends, returns
module mipd_core_model
  import mipd_pkg::*;
#(
  parameter int MC_CLKS = 4
)
(
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic long_instr_in,
  input  wire logic return_from_interrupt_req_in,
  output mipd_core_t core_out
);
  int unsigned clk_cnt;
  int unsigned mc_cnt;

  // ========================================================================
  // Clock and machine-cycle counters; long instructions last three cycles
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      clk_cnt <= 0;
      mc_cnt  <= 0;
    end else begin
      clk_cnt <= (clk_cnt == MC_CLKS - 1) ? 0 : clk_cnt + 1;
      if (clk_cnt == MC_CLKS - 1) begin
        mc_cnt <= core_out.last_cycle ? 0 : mc_cnt + 1;
      end
    end
  end

  // Return is only issued in the final cycle of its instruction, with tick
  always_comb begin
    core_out.tick       = !sys_rst_in && (clk_cnt == MC_CLKS - 1);
    core_out.last_cycle = !long_instr_in || (mc_cnt == 2);
    core_out.return_from_interrupt       = core_out.tick && core_out.last_cycle && return_from_interrupt_req_in;
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
// ==========================================================================
// Bench for the interrupt dispatcher
module tb;
  import mipd_pkg::*;
  logic          clk_in;
  logic          sys_rst_in;
  logic          long_instr;
  logic          return_from_interrupt_req;
  logic          pin0;
  logic          pin1;
  mipd_core_t    core;
  mipd_sfr_req_t sfr;
  mipd_evt_t     evt;
  logic [7:0]    rdata;
  mipd_call_t    call;
  logic [3:0]    insvc;
  int            errors;
  int            check_count;
  logic [7:0]    addrs [5] = '{8'h88, 8'h98, 8'ha8, 8'hb7, 8'hb8};
  logic [7:0]    masks [5] = '{8'haf, 8'h03, 8'h9f, 8'h1f, 8'h1f};

  mipd_core_model core_m (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .long_instr_in(long_instr),
    .return_from_interrupt_req_in(return_from_interrupt_req), .core_out(core));

  mipd_dispatch uut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .core_in(core), .sfr_in(sfr),
    .periph_in(evt), .ext_irq_pin_0_in(pin0), .ext_irq_pin_1_in(pin1),
    .sfr_rdata_out(rdata), .call_out(call), .in_service_out(insvc));

  // ========================================================================
  // Verdict, reached from the main sequence and from every timeout
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Register write; an idle edge follows so strobes never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr <= '{1'b1, a, d};
    @(posedge clk_in);
    sfr.wr <= 1'b0;
    @(posedge clk_in);
  endtask

  // Read data is registered, so it is looked at half a cycle later
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    sfr.addr <= a;
    @(posedge clk_in);
    @(negedge clk_in);
    `CHK(rdata, e)
    @(posedge clk_in);
  endtask

  // Waits for a call; the edge before it must have been an instruction end
  task automatic wait_call(input logic [15:0] v);
    logic took;
    int   n;
    int   mc;
    took = core.tick & core.last_cycle;
    mc = 0;
    for (n = 0; n < 400; n++) begin
      @(posedge clk_in);
      if (call.long_subroutine_call === 1'b1) break;
      took = core.tick & core.last_cycle;
      mc += int'(core.tick);
    end
    if (n == 400) begin
      errors++;
      end_sim();
    end
    `CHK(call.vector, v)
    `CHK(took, 1'b1)
    `CHK(mc < 9, 1'b1)
  endtask

  task automatic quiet(input int c);
    repeat (c) begin
      @(posedge clk_in);
      `CHK(call.long_subroutine_call, 1'b0)
    end
  endtask

  // Holds the return request until the sequencer has issued it
  task automatic do_return_from_interrupt(input logic [3:0] e);
    int n;
    return_from_interrupt_req <= 1'b1;
    for (n = 0; n < 100 && core.return_from_interrupt !== 1'b1; n++) @(posedge clk_in);
    if (n == 100) begin
      errors++;
      end_sim();
    end
    return_from_interrupt_req <= 1'b0;
    @(posedge clk_in);
    `CHK(insvc, e)
  endtask

  task automatic pulse_t(input logic one);
    if (one) evt.t1_roll <= 1'b1;
    else evt.t0_roll <= 1'b1;
    @(posedge clk_in);
    evt <= '0;
    @(posedge clk_in);
  endtask

  // ========================================================================
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Main sequence
  initial begin
    sys_rst_in = 1'b1;
    sfr = '0;
    evt = '0;
    pin0 = 1'b1;
    pin1 = 1'b1;
    long_instr = 1'b0;
    return_from_interrupt_req = 1'b0;
    errors = 0;
    check_count = 0;
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    // Reset values, implemented bits, unmapped address
    for (int i = 0; i < 5; i++) begin
      rd_chk(addrs[i], 8'h00);
      if (i == 0) wr(addrs[i], 8'h05);
      wr(addrs[i], 8'hff);
      rd_chk(addrs[i], masks[i]);
      wr(addrs[i], 8'h00);
    end
    wr(8'h90, 8'hff);
    rd_chk(8'h90, 8'h00);
    // All five pending by software, same level: poll order and vectors
    wr(8'h98, 8'h01);
    wr(8'h88, 8'h05);
    wr(8'h88, 8'haf);
    wr(8'ha8, 8'h9f);
    for (int i = 0; i < 5; i++) begin
      wait_call(16'h0003 + 16'(i * 8));
      `CHK(insvc, 4'h1)
      if (i == 4) rd_chk(8'h98, 8'h01);
      if (i == 4) wr(8'h98, 8'h00);
      do_return_from_interrupt(4'h0);
      quiet(3);
    end
    rd_chk(8'h88, 8'h05);
    // Global enable gates a pending timer flag
    long_instr <= 1'b1;
    wr(8'ha8, 8'h1f);
    pulse_t(1'b0);
    quiet(40);
    rd_chk(8'h88, 8'h25);
    wr(8'ha8, 8'h82);
    wait_call(16'h000b);
    rd_chk(8'h88, 8'h05);
    do_return_from_interrupt(4'h0);
    // Timer 0 at level 1, external 1 at level 3, timer 1 at level 0
    long_instr <= 1'b0;
    wr(8'hb8, 8'h06);
    wr(8'hb7, 8'h04);
    wr(8'ha8, 8'h8e);
    pulse_t(1'b0);
    wait_call(16'h000b);
    `CHK(insvc, 4'h2)
    pulse_t(1'b1);
    quiet(20);
    pin1 <= 1'b0;
    repeat (4) @(posedge clk_in);
    pin1 <= 1'b1;
    wait_call(16'h0013);
    `CHK(insvc, 4'ha)
    do_return_from_interrupt(4'h2);
    do_return_from_interrupt(4'h0);
    wait_call(16'h001b);
    do_return_from_interrupt(4'h0);
    // Level mode on external 0: flag follows the pin, not cleared by vectoring
    wr(8'h88, 8'h04);
    wr(8'ha8, 8'h81);
    pin0 <= 1'b0;
    wait_call(16'h0003);
    rd_chk(8'h88, 8'h06);
    pin0 <= 1'b1;
    repeat (8) @(posedge clk_in);
    do_return_from_interrupt(4'h0);
    quiet(20);
    end_sim();
  end
endmodule
